// *** src/presence_pwm_cfg.svh ***
`ifndef PRESENCE_PWM_CFG_SVH
`define PRESENCE_PWM_CFG_SVH

// =====================================================================
// command addresses
`define ADDR_PWM_FREQ        8'ha3
`define ADDR_IDLE_DUTY       8'ha4
`define ADDR_DETECT_DUTY     8'ha5
`define ADDR_RAMP_UP_HIGH    8'ha6
`define ADDR_RAMP_UP_LOW     8'ha7
`define ADDR_RAMP_DOWN_HIGH  8'ha8
`define ADDR_RAMP_DOWN_LOW   8'ha9
`define ADDR_HOLD_HIGH       8'haa
`define ADDR_HOLD_LOW        8'hab
`define ADDR_PIN_SENS        8'hb0
`define ADDR_SAMPLE_RATE     8'hb1
`define ADDR_RADIO_CHANNEL   8'hb2
`define ADDR_ERROR_CODE      8'hfe
`define ADDR_PARAM_READ      8'hff

// =====================================================================
// reset values
`define RST_PWM_FREQ         7'h04
`define RST_IDLE_DUTY        7'h00
`define RST_DETECT_DUTY      7'h5a
`define RST_RAMP_UP          14'h03e8
`define RST_RAMP_DOWN        14'h03e8
`define RST_HOLD             14'h000a

// =====================================================================
// value limits and field layout
`define FREQ_CODE_MAX        7'h09
`define DUTY_MAX             7'h64
`define SENS_MAX             7'h64
`define RATE_CODE_MAX        7'h04
`define CHANNEL_MAX          7'h09
`define CHANNEL_COUNT        4'ha
`define TIME_SPLIT           7
`define ERR_SYNTAX           8'h01

// =====================================================================
// detection condition codes
`define COND_BOTH            2'h0
`define COND_APPROACH        2'h1
`define COND_LEAVE           2'h2

// =====================================================================
// timing
`define CLK_PERIOD_NS        25
`define RAMP_UNIT_NS         1000000
`define HOLD_UNIT_NS         1000000000
`define CYC_PER_MS           (`RAMP_UNIT_NS / `CLK_PERIOD_NS)
`define CYC_PER_S            (`HOLD_UNIT_NS / `CLK_PERIOD_NS)

`endif

// *** src/presence_pwm_pkg.sv ***
package presence_pwm_pkg;

  // =====================================================================
  // command and answer carriers
  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] param;
  } cmd_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] addr;
    logic [7:0] param;
  } rsp_type;

  // =====================================================================
  // duty engine states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FADE_IN,
    ST_DETECT,
    ST_HOLD,
    ST_FADE_OUT
  } fade_state_type;

endpackage

// *** src/pwm_wave.sv ***
`include "presence_pwm_cfg.svh"

module pwm_wave #(
  parameter int PHASE_MAX = `CYC_PER_MS
) (
  input  wire logic        i_clock,
  input  wire logic        i_srst,
  input  wire logic        i_clock_en,
  input  wire logic        i_enable,
  input  wire logic [3:0]  i_freq_code,
  input  wire logic [15:0] i_level,
  output logic             o_pwm
);

  logic [16:0] phase_q;
  logic [16:0] phase_d;
  logic        pwm_q;
  logic        pwm_d;
  logic [16:0] sum;

  // =====================================================================
  // phase accumulator: step of code+1 kHz per wrap of one millisecond
  always_comb begin
    sum     = phase_q + 17'(i_freq_code) + 17'h00001;
    phase_d = (sum >= 17'(PHASE_MAX)) ? sum - 17'(PHASE_MAX) : sum;
    pwm_d   = i_enable && (phase_q < {1'b0, i_level});
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      phase_q <= 17'h00000;
      pwm_q   <= 1'b0;
    end else if (i_clock_en) begin
      phase_q <= phase_d;
      pwm_q   <= pwm_d;
    end
  end

  assign o_pwm = pwm_q;

endmodule

// *** src/presence_pwm_output_settings.sv ***
`include "presence_pwm_cfg.svh"

// Functional notes
// - PWM frequency code 0..9 gives 1..10 kHz; reset code 4 (5 kHz).
// - no detection drives idle duty, 0..100 percent, reset 0.
// - detection drives detect duty, 0..100 percent, reset 90.
// - on detection ramp toward detect duty over fade-in ms, reset 1000.
// - 14-bit times split: high register bits 13..7, low bits 6..0.
// - after hold expires ramp back over fade-out ms, reset 1000.
// - keep detect duty for hold seconds after target lost, reset 10.
// - read-only pin sensitivity 0..100, applied when analog setting enabled.
// - sensitivity and rate status values keep updating while their feature is disabled.
// - read-only automatic rate code 0..4, applied when auto rate enabled.
// - random channel 0..9 picked once after reset, applied when enabled.
// - status addresses are read-only; writes to them are refused.
// - detection condition selects approach plus leave, approach or leave.
module presence_pwm_output_settings #(
  parameter int CYC_PER_MS = `CYC_PER_MS,
  parameter int CYC_PER_S  = `CYC_PER_S
) (
  input  wire logic                     i_clock,
  input  wire logic                     i_srst,
  input  wire logic                     i_clock_en,
  input  wire presence_pwm_pkg::cmd_type i_cmd,
  output presence_pwm_pkg::rsp_type     o_rsp,
  input  wire logic                     i_pwm_mode,
  input  wire logic                     i_approach,
  input  wire logic                     i_leave,
  input  wire logic [1:0]               i_detect_condition,
  input  wire logic [6:0]               i_pin_sensitivity,
  input  wire logic                     i_analog_sens_en,
  input  wire logic [6:0]               i_manual_sensitivity,
  input  wire logic [2:0]               i_auto_rate,
  input  wire logic                     i_auto_rate_en,
  input  wire logic [2:0]               i_manual_rate,
  input  wire logic [3:0]               i_entropy,
  input  wire logic                     i_random_ch_en,
  input  wire logic [3:0]               i_manual_channel,
  output logic                          o_motion_output_pin,
  output logic [6:0]                    o_applied_sensitivity,
  output logic [2:0]                    o_applied_rate,
  output logic [3:0]                    o_applied_channel,
  output logic [15:0]                   o_duty_level
);

  localparam int PCT_STEP = CYC_PER_MS / 100;
  localparam int SUB_W    = $clog2(CYC_PER_S + 1);

  // =====================================================================
  // settings registers
  logic [6:0] freq_q, freq_d;
  logic [6:0] idle_q, idle_d;
  logic [6:0] detect_q, detect_d;
  logic [6:0] up_hi_q, up_hi_d, up_lo_q, up_lo_d;
  logic [6:0] dn_hi_q, dn_hi_d, dn_lo_q, dn_lo_d;
  logic [6:0] hold_hi_q, hold_hi_d, hold_lo_q, hold_lo_d;
  presence_pwm_pkg::rsp_type rsp_q, rsp_d;
  logic [7:0] read_addr;
  logic [6:0] read_data;
  logic       read_ok;
  logic       write_ok;
  logic [6:0] wval;

  // =====================================================================
  // status values
  logic [6:0] sens_q, sens_d;
  logic [2:0] rate_q, rate_d;
  logic [3:0] chan_q, chan_d;
  logic       picked_q, picked_d;
  logic [6:0] app_sens_q, app_sens_d;
  logic [2:0] app_rate_q, app_rate_d;
  logic [3:0] app_chan_q, app_chan_d;

  // =====================================================================
  // duty engine
  presence_pwm_pkg::fade_state_type state_q, state_d;
  logic [15:0]      level_q, level_d;
  logic [15:0]      target_q, target_d;
  logic [15:0]      delta_q, delta_d;
  logic [29:0]      span_q, span_d;
  logic [30:0]      err_q, err_d;
  logic             rise_q, rise_d;
  logic [SUB_W-1:0] sub_q, sub_d;
  logic [13:0]      sec_q, sec_d;
  logic [13:0]      ramp_up, ramp_dn, hold_time;
  logic [15:0]      idle_lvl, detect_lvl;
  logic             detected;
  logic [30:0]      err_sum;

  // joined 14-bit times
  assign ramp_up   = {up_hi_q, up_lo_q};
  assign ramp_dn   = {dn_hi_q, dn_lo_q};
  assign hold_time = {hold_hi_q, hold_lo_q};
  assign idle_lvl   = 16'(idle_q * PCT_STEP);
  assign detect_lvl = 16'(detect_q * PCT_STEP);

  // detection state chosen by the condition setting
  always_comb begin
    unique case (i_detect_condition)
      `COND_APPROACH: detected = i_approach;
      `COND_LEAVE:    detected = i_leave;
      default:        detected = i_approach | i_leave;
    endcase
  end

  // =====================================================================
  // command decode: writes, reads and refusals
  always_comb begin
    freq_d    = freq_q;
    idle_d    = idle_q;
    detect_d  = detect_q;
    up_hi_d   = up_hi_q;
    up_lo_d   = up_lo_q;
    dn_hi_d   = dn_hi_q;
    dn_lo_d   = dn_lo_q;
    hold_hi_d = hold_hi_q;
    hold_lo_d = hold_lo_q;
    rsp_d     = '0;
    wval      = i_cmd.param[6:0];
    read_addr = {1'b1, i_cmd.param[6:0]};
    read_ok   = 1'b1;
    read_data = 7'h00;
    unique case (read_addr)
      `ADDR_PWM_FREQ:       read_data = freq_q;
      `ADDR_IDLE_DUTY:      read_data = idle_q;
      `ADDR_DETECT_DUTY:    read_data = detect_q;
      `ADDR_RAMP_UP_HIGH:   read_data = up_hi_q;
      `ADDR_RAMP_UP_LOW:    read_data = up_lo_q;
      `ADDR_RAMP_DOWN_HIGH: read_data = dn_hi_q;
      `ADDR_RAMP_DOWN_LOW:  read_data = dn_lo_q;
      `ADDR_HOLD_HIGH:      read_data = hold_hi_q;
      `ADDR_HOLD_LOW:       read_data = hold_lo_q;
      `ADDR_PIN_SENS:       read_data = sens_q;
      `ADDR_SAMPLE_RATE:    read_data = {4'h0, rate_q};
      `ADDR_RADIO_CHANNEL:  read_data = {3'h0, chan_q};
      default:              read_ok   = 1'b0;
    endcase
    write_ok = 1'b0;
    if (i_cmd.valid && !i_cmd.param[7]) begin
      unique case (i_cmd.addr)
        `ADDR_PWM_FREQ: begin
          write_ok = (wval <= `FREQ_CODE_MAX);
          if (write_ok) freq_d = wval;
        end
        `ADDR_IDLE_DUTY: begin
          write_ok = (wval <= `DUTY_MAX);
          if (write_ok) idle_d = wval;
        end
        `ADDR_DETECT_DUTY: begin
          write_ok = (wval <= `DUTY_MAX);
          if (write_ok) detect_d = wval;
        end
        `ADDR_RAMP_UP_HIGH: begin
          write_ok = 1'b1;
          up_hi_d  = wval;
        end
        `ADDR_RAMP_UP_LOW: begin
          write_ok = 1'b1;
          up_lo_d  = wval;
        end
        `ADDR_RAMP_DOWN_HIGH: begin
          write_ok = 1'b1;
          dn_hi_d  = wval;
        end
        `ADDR_RAMP_DOWN_LOW: begin
          write_ok = 1'b1;
          dn_lo_d  = wval;
        end
        `ADDR_HOLD_HIGH: begin
          write_ok  = 1'b1;
          hold_hi_d = wval;
        end
        `ADDR_HOLD_LOW: begin
          write_ok  = 1'b1;
          hold_lo_d = wval;
        end
        `ADDR_PARAM_READ: write_ok = read_ok;
        default:          write_ok = 1'b0;  // status writes refused
      endcase
    end
    // one answer per command: echo, read data or syntax error
    if (i_cmd.valid) begin
      rsp_d.valid = 1'b1;
      if (!write_ok) begin
        rsp_d.addr  = `ADDR_ERROR_CODE;
        rsp_d.param = `ERR_SYNTAX;
      end else if (i_cmd.addr == `ADDR_PARAM_READ) begin
        rsp_d.addr  = read_addr;
        rsp_d.param = {1'b0, read_data};
      end else begin
        rsp_d.addr  = i_cmd.addr;
        rsp_d.param = i_cmd.param;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      freq_q    <= `RST_PWM_FREQ;
      idle_q    <= `RST_IDLE_DUTY;
      detect_q  <= `RST_DETECT_DUTY;
      up_hi_q   <= 7'(`RST_RAMP_UP >> `TIME_SPLIT);
      up_lo_q   <= 7'(`RST_RAMP_UP & 14'h007f);
      dn_hi_q   <= 7'(`RST_RAMP_DOWN >> `TIME_SPLIT);
      dn_lo_q   <= 7'(`RST_RAMP_DOWN & 14'h007f);
      hold_hi_q <= 7'(`RST_HOLD >> `TIME_SPLIT);
      hold_lo_q <= 7'(`RST_HOLD & 14'h007f);
      rsp_q     <= '0;
    end else if (i_clock_en) begin
      freq_q    <= freq_d;
      idle_q    <= idle_d;
      detect_q  <= detect_d;
      up_hi_q   <= up_hi_d;
      up_lo_q   <= up_lo_d;
      dn_hi_q   <= dn_hi_d;
      dn_lo_q   <= dn_lo_d;
      hold_hi_q <= hold_hi_d;
      hold_lo_q <= hold_lo_d;
      rsp_q     <= rsp_d;
    end
  end

  // =====================================================================
  // status tracking and applied selections
  always_comb begin
    sens_d   = (i_pin_sensitivity > `SENS_MAX) ? `SENS_MAX
                                              : i_pin_sensitivity;
    rate_d   = (i_auto_rate > 3'(`RATE_CODE_MAX)) ? 3'(`RATE_CODE_MAX)
                                                  : i_auto_rate;
    chan_d   = chan_q;
    picked_d = 1'b1;
    if (!picked_q) begin
      chan_d = (i_entropy >= `CHANNEL_COUNT) ? i_entropy - `CHANNEL_COUNT
                                             : i_entropy;
    end
    app_sens_d = i_analog_sens_en ? sens_q : i_manual_sensitivity;
    app_rate_d = i_auto_rate_en ? rate_q : i_manual_rate;
    app_chan_d = i_random_ch_en ? chan_q : i_manual_channel;
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sens_q     <= 7'h00;
      rate_q     <= 3'h0;
      chan_q     <= 4'h0;
      picked_q   <= 1'b0;
      app_sens_q <= 7'h00;
      app_rate_q <= 3'h0;
      app_chan_q <= 4'h0;
    end else if (i_clock_en) begin
      sens_q     <= sens_d;
      rate_q     <= rate_d;
      chan_q     <= chan_d;
      picked_q   <= picked_d;
      app_sens_q <= app_sens_d;
      app_rate_q <= app_rate_d;
      app_chan_q <= app_chan_d;
    end
  end

  // =====================================================================
  // duty engine: idle, fade in, detect, hold, fade out
  always_comb begin
    state_d  = state_q;
    level_d  = level_q;
    target_d = target_q;
    delta_d  = delta_q;
    span_d   = span_q;
    err_d    = err_q;
    rise_d   = rise_q;
    sub_d    = sub_q;
    sec_d    = sec_q;
    err_sum  = err_q + {15'h0000, delta_q};
    unique case (state_q)
      presence_pwm_pkg::ST_IDLE: begin
        level_d = idle_lvl;
        if (detected) begin
          state_d  = presence_pwm_pkg::ST_FADE_IN;
          target_d = detect_lvl;
          span_d   = 30'(ramp_up * CYC_PER_MS);
          rise_d   = detect_lvl >= level_q;
          delta_d  = (detect_lvl >= level_q) ? detect_lvl - level_q
                                             : level_q - detect_lvl;
          err_d    = '0;
        end
      end
      presence_pwm_pkg::ST_DETECT: begin
        level_d = detect_lvl;
        if (!detected) begin
          state_d = presence_pwm_pkg::ST_HOLD;
          sub_d   = '0;
          sec_d   = 14'h0000;
        end
      end
      presence_pwm_pkg::ST_HOLD: begin
        level_d = detect_lvl;
        if (detected) begin
          state_d = presence_pwm_pkg::ST_DETECT;
        end else if (sec_q >= hold_time) begin
          state_d  = presence_pwm_pkg::ST_FADE_OUT;
          target_d = idle_lvl;
          span_d   = 30'(ramp_dn * CYC_PER_MS);
          rise_d   = idle_lvl >= level_q;
          delta_d  = (idle_lvl >= level_q) ? idle_lvl - level_q
                                           : level_q - idle_lvl;
          err_d    = '0;
        end else if (sub_q == SUB_W'(CYC_PER_S - 1)) begin
          sub_d = '0;
          sec_d = sec_q + 14'h0001;
        end else begin
          sub_d = sub_q + SUB_W'(1);
        end
      end
      default: begin
        // both fades: one error-accumulated step at most per cycle
        if (level_q == target_q || span_q == '0) begin
          level_d = target_q;
          state_d = (state_q == presence_pwm_pkg::ST_FADE_IN)
                  ? presence_pwm_pkg::ST_DETECT
                  : presence_pwm_pkg::ST_IDLE;
        end else begin
          err_d = err_sum;
          if (err_sum >= {1'b0, span_q}) begin
            err_d   = err_sum - {1'b0, span_q};
            level_d = rise_q ? level_q + 16'h0001
                             : level_q - 16'h0001;
          end
        end
        if (state_q == presence_pwm_pkg::ST_FADE_OUT && detected) begin
          state_d  = presence_pwm_pkg::ST_FADE_IN;
          target_d = detect_lvl;
          span_d   = 30'(ramp_up * CYC_PER_MS);
          rise_d   = detect_lvl >= level_q;
          delta_d  = (detect_lvl >= level_q) ? detect_lvl - level_q
                                             : level_q - detect_lvl;
          err_d    = '0;
          level_d  = level_q;
        end
      end
    endcase
  end

  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      state_q  <= presence_pwm_pkg::ST_IDLE;
      level_q  <= 16'h0000;
      target_q <= 16'h0000;
      delta_q  <= 16'h0000;
      span_q   <= '0;
      err_q    <= '0;
      rise_q   <= 1'b0;
      sub_q    <= '0;
      sec_q    <= 14'h0000;
    end else if (i_clock_en) begin
      state_q  <= state_d;
      level_q  <= level_d;
      target_q <= target_d;
      delta_q  <= delta_d;
      span_q   <= span_d;
      err_q    <= err_d;
      rise_q   <= rise_d;
      sub_q    <= sub_d;
      sec_q    <= sec_d;
    end
  end

  // =====================================================================
  // waveform on the motion output pin
  pwm_wave #(
    .PHASE_MAX (CYC_PER_MS)
  ) u_wave (
    .i_clock     (i_clock),
    .i_srst      (i_srst),
    .i_clock_en  (i_clock_en),
    .i_enable    (i_pwm_mode),
    .i_freq_code (freq_q[3:0]),
    .i_level     (level_q),
    .o_pwm       (o_motion_output_pin)
  );

  assign o_rsp                 = rsp_q;
  assign o_applied_sensitivity = app_sens_q;
  assign o_applied_rate        = app_rate_q;
  assign o_applied_channel     = app_chan_q;
  assign o_duty_level          = level_q;

endmodule

// *** tb/presence_pwm_output_settings_assertions.sv ***
module presence_pwm_output_settings_assertions #(
  parameter int CYC_PER_MS = 1000
) (
  input wire logic                      i_clock,
  input wire logic                      i_srst,
  input wire logic                      i_clock_en,
  input wire presence_pwm_pkg::cmd_type i_cmd,
  input wire presence_pwm_pkg::rsp_type o_rsp,
  input wire logic                      i_pwm_mode,
  input wire logic [6:0]                i_pin_sensitivity,
  input wire logic                      i_analog_sens_en,
  input wire logic [6:0]                i_manual_sensitivity,
  input wire logic [2:0]                i_auto_rate,
  input wire logic                      i_auto_rate_en,
  input wire logic [2:0]                i_manual_rate,
  input wire logic                      o_motion_output_pin,
  input wire logic [6:0]                o_applied_sensitivity,
  input wire logic [2:0]                o_applied_rate,
  input wire logic [15:0]               o_duty_level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [6:0] sens_want;
  logic [2:0] rate_want;
  logic       take;
  logic [6:0] sens_seen_q;
  logic [2:0] rate_seen_q;

  // =====================================================================
  // status values as registered one enabled cycle earlier
  always_ff @(posedge i_clock) begin
    if (i_srst) begin
      sens_seen_q <= 7'h00;
      rate_seen_q <= 3'h0;
    end else if (i_clock_en) begin
      sens_seen_q <= (i_pin_sensitivity > 7'h64) ? 7'h64 : i_pin_sensitivity;
      rate_seen_q <= (i_auto_rate > 3'h4) ? 3'h4 : i_auto_rate;
    end
  end

  // =====================================================================
  // expected selections from the live inputs
  always_comb begin
    take = i_clock_en && i_cmd.valid;
    sens_want = i_manual_sensitivity;
    rate_want = i_manual_rate;
    if (i_analog_sens_en) begin
      sens_want = sens_seen_q;
    end
    if (i_auto_rate_en) begin
      rate_want = rate_seen_q;
    end
  end

  default clocking @(posedge i_clock); endclocking
  default disable iff (i_srst);

  // =====================================================================
  // command answers
  a_ro_refused: assert property (take && i_cmd.addr inside
    {8'hb0, 8'hb1, 8'hb2} |=> o_rsp == {1'b1, 8'hfe, 8'h01})
    else $error("status write not refused");
  a_freq_refused: assert property (take && i_cmd.addr == 8'ha3 &&
    i_cmd.param > 8'h09 |=> o_rsp == {1'b1, 8'hfe, 8'h01})
    else $error("bad frequency code not refused");
  a_duty_refused: assert property (take && i_cmd.param > 8'h64 &&
    i_cmd.addr inside {8'ha4, 8'ha5} |=> o_rsp.addr == 8'hfe)
    else $error("bad duty not refused");
  a_duty_echo: assert property (take && i_cmd.addr == 8'ha5 &&
    i_cmd.param <= 8'h64 |=> o_rsp == {1'b1, 8'ha5, $past(i_cmd.param)})
    else $error("duty write not echoed");

  // =====================================================================
  // applied selections
  a_sens_select: assert property (i_clock_en |=>
    o_applied_sensitivity == $past(sens_want))
    else $error("applied sensitivity wrong");
  a_rate_select: assert property (i_clock_en |=>
    o_applied_rate == $past(rate_want))
    else $error("applied rate wrong");

  // =====================================================================
  // output pin and duty level
  a_pin_off: assert property (i_clock_en && !i_pwm_mode |=>
    !o_motion_output_pin) else $error("pin high outside pwm mode");
  a_pwm_full: assert property (i_clock_en && i_pwm_mode &&
    o_duty_level == 16'(CYC_PER_MS) |=> o_motion_output_pin)
    else $error("pin low at full duty");
  a_duty_range: assert property (o_duty_level <= 16'(CYC_PER_MS))
    else $error("duty level above full scale");
endmodule

bind presence_pwm_output_settings presence_pwm_output_settings_assertions
  #(.CYC_PER_MS(CYC_PER_MS)) chk_i (
  .i_clock(i_clock), .i_srst(i_srst), .i_clock_en(i_clock_en),
  .i_cmd(i_cmd), .o_rsp(o_rsp), .i_pwm_mode(i_pwm_mode),
  .i_pin_sensitivity(i_pin_sensitivity),
  .i_analog_sens_en(i_analog_sens_en),
  .i_manual_sensitivity(i_manual_sensitivity),
  .i_auto_rate(i_auto_rate), .i_auto_rate_en(i_auto_rate_en),
  .i_manual_rate(i_manual_rate),
  .o_motion_output_pin(o_motion_output_pin),
  .o_applied_sensitivity(o_applied_sensitivity),
  .o_applied_rate(o_applied_rate), .o_duty_level(o_duty_level));

// *** tb/host_cmd_model.sv ***
module host_cmd_model (
  input  wire logic                      i_clock,
  input  wire presence_pwm_pkg::rsp_type i_rsp,
  output presence_pwm_pkg::cmd_type      o_cmd
);
  timeunit 1ns;
  timeprecision 1ps;

  initial o_cmd = '0;

  // =====================================================================
  // one address byte and one parameter byte, answer one cycle later
  task automatic xfer(input logic [7:0] a, p,
                      output presence_pwm_pkg::rsp_type r);
    @(posedge i_clock);
    o_cmd <= '{1'b1, a, p};
    @(posedge i_clock);
    o_cmd <= '0;
    #1 r = i_rsp;
  endtask

  // 14-bit time sent as high then low half
  task automatic wr14(input logic [7:0] a, input logic [13:0] v);
    presence_pwm_pkg::rsp_type r;
    xfer(a, {1'b0, v[13:7]}, r);
    xfer(a + 8'h01, {1'b0, v[6:0]}, r);
  endtask

  // any place, status or setting, is read through the parameter read address
  task automatic rd(input logic [7:0] a,
                    output presence_pwm_pkg::rsp_type r);
    xfer(8'hff, {1'b0, a[6:0]}, r);
  endtask
endmodule

// *** tb/presence_pwm_output_settings_tb.sv ***
module presence_pwm_output_settings_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clock = 1'b0;
  logic        srst = 1'b1;
  logic        clock_en = 1'b1;
  logic        pwm_mode = 1'b0;
  logic        appr = 1'b0;
  logic        leave = 1'b0;
  logic [1:0]  cond = 2'h0;
  logic [6:0]  pin_sens = 7'h2a;
  logic        sens_en = 1'b0;
  logic [2:0]  auto_rate = 3'h3;
  logic        rate_en = 1'b0;
  logic [3:0]  entropy = 4'h3;
  logic        ch_en = 1'b0;
  logic        pin;
  logic [6:0]  a_sens;
  logic [2:0]  a_rate;
  logic [3:0]  a_ch;
  logic [15:0] level;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          n;
  presence_pwm_pkg::cmd_type cmd;
  presence_pwm_pkg::rsp_type rsp;
  presence_pwm_pkg::rsp_type r;
  localparam logic [16:0] err_rsp = {1'b1, 8'hfe, 8'h01};

  always #12.5 clock = ~clock;

  host_cmd_model host (.i_clock(clock), .i_rsp(rsp), .o_cmd(cmd));

  presence_pwm_output_settings #(.CYC_PER_MS(1000), .CYC_PER_S(200)) uut (
    .i_clock(clock), .i_srst(srst), .i_clock_en(clock_en), .i_cmd(cmd),
    .o_rsp(rsp), .i_pwm_mode(pwm_mode), .i_approach(appr),
    .i_leave(leave), .i_detect_condition(cond),
    .i_pin_sensitivity(pin_sens), .i_analog_sens_en(sens_en),
    .i_manual_sensitivity(7'h14), .i_auto_rate(auto_rate),
    .i_auto_rate_en(rate_en), .i_manual_rate(3'h1), .i_entropy(entropy),
    .i_random_ch_en(ch_en), .i_manual_channel(4'h5),
    .o_motion_output_pin(pin), .o_applied_sensitivity(a_sens),
    .o_applied_rate(a_rate), .o_applied_channel(a_ch),
    .o_duty_level(level));

  // =====================================================================
  // comparison, level polling and verdict
  task automatic chk(input logic [16:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_lvl(input logic [15:0] exp, input int lim,
                          input logic up, output int cnt);
    logic [15:0] prev;
    logic        mono;
    prev = level;
    mono = 1'b1;
    cnt = 0;
    while (level !== exp && cnt < lim) begin
      @(posedge clock);
      #1;
      if (up ? level < prev : level > prev) mono = 1'b0;
      prev = level;
      cnt++;
    end
    chk({1'b0, level}, {1'b0, exp});
    chk({16'h0, mono}, 17'h1);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // =====================================================================
  // scenarios
  task automatic t_reset;
    logic [7:0] tab [9] = '{8'h04, 8'h00, 8'h5a, 8'h07, 8'h68,
                            8'h07, 8'h68, 8'h00, 8'h0a};
    for (int i = 0; i < 9; i++) begin
      host.rd(8'ha3 + 8'(i), r);
      chk(r, {1'b1, 8'ha3 + 8'(i), tab[i]});
    end
    $display("test reset values done");
  endtask

  task automatic t_access;
    for (int c = 0; c < 11; c++) begin
      host.xfer(8'ha3, 8'(c), r);
      chk(r, (c < 10) ? {1'b1, 8'ha3, 8'(c)} : err_rsp);
    end
    host.rd(8'ha3, r);
    chk(r, {1'b1, 8'ha3, 8'h09});
    host.xfer(8'ha4, 8'h65, r);
    chk(r, err_rsp);
    host.xfer(8'ha4, 8'h80, r);
    chk(r, err_rsp);
    host.xfer(8'ha5, 8'h64, r);
    chk(r, {1'b1, 8'ha5, 8'h64});
    for (int i = 0; i < 3; i++) begin
      host.xfer(8'hb0 + 8'(i), 8'h01, r);
      chk(r, err_rsp);
    end
    host.rd(8'hfe, r);
    chk(r, err_rsp);
    $display("test access done");
  endtask

  task automatic t_status;
    host.rd(8'hb0, r);
    chk(r, {1'b1, 8'hb0, 8'h2a});
    host.rd(8'hb1, r);
    chk(r, {1'b1, 8'hb1, 8'h03});
    chk({13'h0, a_ch}, 17'h5);
    @(posedge clock);
    {sens_en, rate_en, ch_en} <= 3'b111;
    pin_sens <= 7'h70;
    entropy <= 4'h7;
    repeat (2) @(posedge clock);
    #1;
    chk({10'h0, a_sens}, 17'h64);
    chk({14'h0, a_rate}, 17'h3);
    chk({13'h0, a_ch}, 17'h3);
    host.rd(8'hb2, r);
    chk(r, {1'b1, 8'hb2, 8'h03});
    $display("test status done");
  endtask

  task automatic t_fade;
    @(posedge clock);
    pwm_mode <= 1'b1;
    host.xfer(8'ha4, 8'h0a, r);
    host.xfer(8'ha5, 8'h32, r);
    host.wr14(8'ha6, 14'd2);
    host.wr14(8'ha8, 14'd2);
    host.wr14(8'haa, 14'd1);
    repeat (3) @(posedge clock);
    #1;
    chk({1'b0, level}, 17'd100);
    n = 0;
    repeat (100) begin
      @(posedge clock);
      #1;
      n += int'(pin);
    end
    chk(17'(n), 17'd10);
    @(posedge clock);
    appr <= 1'b1;
    #1;
    wait_lvl(16'd500, 2100, 1'b1, n);
    chk({16'h0, n >= 1995 && n <= 2010}, 17'h1);
    @(posedge clock);
    appr <= 1'b0;
    repeat (150) @(posedge clock);
    #1;
    chk({1'b0, level}, 17'd500);
    wait_lvl(16'd100, 2300, 1'b0, n);
    chk({16'h0, n >= 2040 && n <= 2070}, 17'h1);
    $display("test fade done");
  endtask

  task automatic t_cond;
    logic [3:0] cs [6] = '{4'h2, 4'h1, 4'h6, 4'h5, 4'ha, 4'h9};
    logic [5:0] hit = 6'b100111;
    host.xfer(8'ha5, 8'h64, r);
    host.wr14(8'ha6, 14'd0);
    host.wr14(8'ha8, 14'd0);
    host.wr14(8'haa, 14'd0);
    for (int i = 0; i < 6; i++) begin
      @(posedge clock);
      {cond, appr, leave} <= cs[i];
      repeat (8) @(posedge clock);
      #1;
      chk({1'b0, level}, hit[i] ? 17'd1000 : 17'd100);
      @(posedge clock);
      {appr, leave} <= 2'b00;
      repeat (8) @(posedge clock);
    end
    $display("test condition done");
  endtask

  // =====================================================================
  // main sequence and watchdog
  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    t_reset;
    t_access;
    t_status;
    t_fade;
    t_cond;
    summarize;
  end

  initial begin
    #(25 * 30000);
    n_mismatch++;
    summarize;
  end
endmodule
